// file: src/tlbm_top.sv
// TLB maintenance unit: probe, indexed read, indexed or random write.
// Assumes instructions arrive on the core clock, one per valid cycle,
// and that APB runs on the same clock.
// Behaviour
// - Probe loads the pointer with the index of the matching entry.
// - Probe miss sets pointer bit 31; lower bits unpredictable.
// - Release 2 reports multiple matches on writes only; 3 also probes.
// - Release 3 may detect multiple matches during a read.
// - Without coprocessor access enabled, raise coprocessor unusable.
// - Release 6 with block or fixed MMU type raises reserved instruction.
// - Decode major opcode 010000, bit 25 set, bits 24..6 zero.
// - Read copies the pointed entry into the four staging registers.
// - Reading an invalidated entry returns zeros, request bit, min mask.
// - Read may zero page and frame bits covered by the entry mask.
// - Read presents the single stored global bit in both page registers.
// - Normal indexed write stores staging registers at the pointer.
// - Multiple matches during a write raise machine check.
// - Write may zero page and frame bits covered by the page mask.
// - Write stores the AND of both staging global bits.
// - Invalidating write marks the entry invalid, never machine check.
// - Random write stores staging registers at the replacement pointer.
// - Release 6 hides the replacement pointer from software.
`timescale 1ns/1ps
module tlbm_top
  import tlbm_pkg::*;
#(
  parameter int   N_ENTRIES    = 16,
  parameter bit   DETECT_MULTI = 1'b1,
  parameter bit   ZERO_MASKED  = 1'b1
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_arst_n,
  input  wire tlbm_apb_req_t i_apb,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  input  wire logic          i_instr_valid,
  input  wire logic [31:0]   i_instr,
  input  wire logic          i_cp0_en,
  output logic               o_instr_done,
  output tlbm_exc_t          o_exc
);
  localparam int IDX_W = (N_ENTRIES > 2) ? $clog2(N_ENTRIES) : 1;
  localparam tlbm_entry_t ENTRY_RST = '{inv: 1'b1, default: '0};

  tlbm_entry_t      tlb [N_ENTRIES];
  logic [31:0]      tag_r, lo0_r, lo1_r, pm_r, cfg_r, prdata_r;
  logic [IDX_W-1:0] idx_r, rnd_r, first_c, wr_idx;
  logic             miss_r, done_r;
  tlbm_exc_t        exc_r;
  logic [2:0]       mt, rel;
  logic [1:0]       ie;
  logic             dec, op_probe, op_read, op_wri, op_wrr;
  logic             exc_cpu, exc_ri, go, mc, wr_inv, wr_norm, multi;
  logic [N_ENTRIES-1:0] ph, wh, rh;
  logic [VPN_W-1:0] t_vpn;
  logic [1:0]       t_r;
  logic [ADDRESS_SPACE_ID_W-1:0] t_address_space_id;
  logic [MSK_W-1:0] p_msk, zmask;
  tlbm_entry_t      e, wr_e;
  logic [31:0]      rd_tag, rd_lo0, rd_lo1, rd_pm, rd_mux;
  logic             mapped, apb_wr;

  function automatic logic hit(tlbm_entry_t en,
                               logic [VPN_W-1:0] v,
                               logic [1:0] r,
                               logic [ADDRESS_SPACE_ID_W-1:0] a,
                               logic [MSK_W-1:0] m,
                               logic g);
    logic [VPN_W-1:0] keep;
    keep = ~{{(VPN_W-MSK_W){1'b0}}, en.msk | m};
    hit = !en.inv && ((en.vpn & keep) == (v & keep)) &&
          (en.r == r) && (en.g || g || (en.address_space_id == a));
  endfunction : hit

  assign mt     = cfg_r[CFG_MT_LSB +: 3];
  assign ie     = cfg_r[CFG_IE_LSB +: 2];
  assign rel    = cfg_r[CFG_REL_LSB +: 3];
  assign t_vpn  = tag_r[TAG_VPN_LSB +: VPN_W];
  assign t_r    = tag_r[TAG_R_LSB +: 2];
  assign t_address_space_id = tag_r[ADDRESS_SPACE_ID_W-1:0];
  assign p_msk  = pm_r[PM_LSB +: MSK_W];

  // Instruction decode and exception priority.
  assign dec = (i_instr[31:26] == OPC_COP0) && i_instr[25] &&
               (i_instr[24:6] == 19'h00000);
  assign op_probe = dec && (i_instr[5:0] == FN_PROBE);
  assign op_read  = dec && (i_instr[5:0] == FN_READ);
  assign op_wri   = dec && (i_instr[5:0] == FN_WRI);
  assign op_wrr   = dec && (i_instr[5:0] == FN_WRR);
  assign exc_cpu  = !i_cp0_en;
  assign exc_ri   = i_cp0_en && (rel >= REL_R6) &&
                    ((mt == MT_BAT) || (mt == MT_FM));
  assign go = i_instr_valid && (op_probe || op_read || op_wri || op_wrr)
              && !exc_cpu && !exc_ri;

  assign e       = tlb[idx_r];
  assign wr_inv  = op_wri && (ie != 2'h0) && tag_r[TAG_INV_BIT];
  assign wr_norm = (op_wri && !wr_inv) || op_wrr;
  assign wr_idx  = op_wrr ? rnd_r : idx_r;
  assign zmask   = ZERO_MASKED ? p_msk : MIN_PAGE_MASK;

  // Hit vectors for probe, write overlap and read overlap checks.
  always_comb begin
    ph      = '0;
    wh      = '0;
    rh      = '0;
    first_c = '0;
    for (int i = N_ENTRIES - 1; i >= 0; i--) begin
      ph[i] = hit(tlb[i], t_vpn, t_r, t_address_space_id, '0, 1'b0);
      wh[i] = (IDX_W'(i) != wr_idx) &&
              hit(tlb[i], t_vpn, t_r, t_address_space_id, p_msk,
                  lo0_r[LO_G_BIT] & lo1_r[LO_G_BIT]);
      rh[i] = (IDX_W'(i) != idx_r) && !e.inv &&
              hit(tlb[i], e.vpn, e.r, e.address_space_id, e.msk, e.g);
      if (ph[i]) begin
        first_c = IDX_W'(i);
      end
    end
  end

  assign multi = (ph & (ph - {{(N_ENTRIES-1){1'b0}}, 1'b1})) != '0;
  // Probe and read overlap detection is gated per release so that older software never
  // sees a machine check on a probe or read; write overlap detection is not.
  assign mc = DETECT_MULTI && (
                (wr_norm && (|wh)) ||
                ((rel >= REL_R3) && op_probe && multi) ||
                ((rel >= REL_R3) && op_read && (|rh)));

  // New entry from staging registers.
  always_comb begin
    wr_e      = '0;
    wr_e.vpn  = t_vpn & ~{{(VPN_W-MSK_W){1'b0}}, zmask};
    wr_e.r    = t_r;
    wr_e.address_space_id = t_address_space_id;
    wr_e.msk  = p_msk;
    wr_e.g    = lo0_r[LO_G_BIT] & lo1_r[LO_G_BIT];
    wr_e.pfn0 = lo0_r[LO_PFN_LSB +: PFN_W] &
                ~{{(PFN_W-MSK_W){1'b0}}, zmask};
    wr_e.pfn1 = lo1_r[LO_PFN_LSB +: PFN_W] &
                ~{{(PFN_W-MSK_W){1'b0}}, zmask};
    wr_e.c0   = lo0_r[LO_C_LSB +: 3];
    wr_e.d0   = lo0_r[LO_D_BIT];
    wr_e.v0   = lo0_r[LO_V_BIT];
    wr_e.c1   = lo1_r[LO_C_LSB +: 3];
    wr_e.d1   = lo1_r[LO_D_BIT];
    wr_e.v1   = lo1_r[LO_V_BIT];
  end

  // Staging values returned by a read.
  always_comb begin
    rd_tag = '0;
    rd_lo0 = '0;
    rd_lo1 = '0;
    rd_pm  = '0;
    if ((ie != 2'h0) && e.inv) begin
      rd_tag[TAG_INV_BIT]     = 1'b1;
      rd_pm[PM_LSB +: MSK_W]  = MIN_PAGE_MASK;
    end else begin
      rd_tag[TAG_VPN_LSB +: VPN_W] = e.vpn;
      rd_tag[TAG_R_LSB +: 2]       = e.r;
      rd_tag[ADDRESS_SPACE_ID_W-1:0]           = e.address_space_id;
      rd_pm[PM_LSB +: MSK_W]       = e.msk;
      rd_lo0[LO_PFN_LSB +: PFN_W]  = e.pfn0;
      rd_lo0[LO_C_LSB +: 3]        = e.c0;
      rd_lo0[LO_D_BIT]             = e.d0;
      rd_lo0[LO_V_BIT]             = e.v0;
      rd_lo0[LO_G_BIT]             = e.g;
      rd_lo1[LO_PFN_LSB +: PFN_W]  = e.pfn1;
      rd_lo1[LO_C_LSB +: 3]        = e.c1;
      rd_lo1[LO_D_BIT]             = e.d1;
      rd_lo1[LO_V_BIT]             = e.v1;
      rd_lo1[LO_G_BIT]             = e.g;
    end
  end

  // Entry array. Out-of-range indices are left alone to stay safe.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < N_ENTRIES; i++) begin
        tlb[i] <= ENTRY_RST;
      end
    end else if (go && !mc) begin
      if (wr_inv) begin
        tlb[idx_r].inv <= 1'b1;
      end else if (wr_norm && (int'(wr_idx) < N_ENTRIES)) begin
        tlb[wr_idx] <= wr_e;
      end
    end
  end

  assign apb_wr = i_apb.psel && i_apb.penable && i_apb.pwrite;

  // Staging registers; a read instruction wins over a same-cycle APB write.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tag_r <= REG_RST;
      lo0_r <= REG_RST;
      lo1_r <= REG_RST;
      pm_r  <= REG_RST;
    end else if (go && !mc && op_read) begin
      tag_r <= rd_tag;
      lo0_r <= rd_lo0;
      lo1_r <= rd_lo1;
      pm_r  <= rd_pm;
    end else if (apb_wr) begin
      case (i_apb.paddr)
        OFS_TAG:  tag_r <= i_apb.pwdata & TAG_WMASK;
        OFS_EVEN: lo0_r <= i_apb.pwdata & LO_WMASK;
        OFS_ODD:  lo1_r <= i_apb.pwdata & LO_WMASK;
        OFS_MASK: pm_r  <= i_apb.pwdata & PM_WMASK;
        default: ;
      endcase
    end
  end

  // Entry pointer.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_r  <= '0;
      miss_r <= 1'b0;
    end else if (go && !mc && op_probe) begin
      miss_r <= !(|ph);
      idx_r  <= first_c;
    end else if (apb_wr && (i_apb.paddr == OFS_PTR)) begin
      miss_r <= i_apb.pwdata[PTR_MISS];
      idx_r  <= i_apb.pwdata[IDX_W-1:0];
    end
  end

  // Replacement pointer walks down through the array every cycle.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rnd_r <= '0;
    end else if (rnd_r == '0) begin
      rnd_r <= IDX_W'(N_ENTRIES - 1);
    end else begin
      rnd_r <= rnd_r - {{(IDX_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= CFG_RST;
    end else if (apb_wr && (i_apb.paddr == OFS_CFG)) begin
      cfg_r <= i_apb.pwdata & CFG_WMASK;
    end
  end

  // Completion and exceptions are reported one cycle after issue.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_r <= 1'b0;
      exc_r  <= '0;
    end else begin
      done_r <= i_instr_valid &&
                (op_probe || op_read || op_wri || op_wrr);
      if (i_instr_valid && (op_probe || op_read || op_wri || op_wrr)) begin
        exc_r.cpu  <= exc_cpu;
        exc_r.ri   <= exc_ri;
        exc_r.mchk <= go && mc;
      end else begin
        exc_r <= '0;
      end
    end
  end

  assign o_instr_done = done_r;
  assign o_exc        = exc_r;

  // APB slave: read data is captured in the setup cycle, zero wait state.
  always_comb begin
    mapped = 1'b1;
    case (i_apb.paddr)
      OFS_TAG:  rd_mux = tag_r;
      OFS_EVEN: rd_mux = lo0_r;
      OFS_ODD:  rd_mux = lo1_r;
      OFS_MASK: rd_mux = pm_r;
      OFS_PTR:  rd_mux = {miss_r, {(31-IDX_W){1'b0}}, idx_r};
      OFS_RAND: rd_mux = (rel >= REL_R6) ? 32'h0000_0000
                         : {{(32-IDX_W){1'b0}}, rnd_r};
      OFS_CFG:  rd_mux = cfg_r;
      OFS_STAT: rd_mux = {29'h0000_0000, exc_r};
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_r <= REG_RST;
    end else if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_apb.psel && i_apb.penable && !mapped;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_probe_hit;
    go && op_probe && !mc && (|ph) |=> !miss_r && idx_r == $past(first_c);
  endproperty
  a_probe_hit: assert property (p_probe_hit)
    else $error("probe hit did not load pointer");

  property p_probe_miss;
    go && op_probe && !(|ph) |=> miss_r;
  endproperty
  a_probe_miss: assert property (p_probe_miss)
    else $error("probe miss did not set top bit");

  property p_old_rel;
    i_instr_valid && (op_probe || op_read) && rel < REL_R3 |=> !o_exc.mchk;
  endproperty
  a_old_rel: assert property (p_old_rel)
    else $error("machine check on probe or read before release 3");

  property p_cpu;
    i_instr_valid && op_read && !i_cp0_en |=> o_instr_done && o_exc.cpu
      && $stable(tag_r);
  endproperty
  a_cpu: assert property (p_cpu)
    else $error("coprocessor unusable not raised");

  property p_ri;
    i_instr_valid && op_wri && i_cp0_en && rel >= REL_R6 &&
      mt == MT_FM |=> o_exc.ri && !o_exc.cpu;
  endproperty
  a_ri: assert property (p_ri)
    else $error("reserved instruction not raised");

  property p_decode;
    i_instr_valid && !i_instr[25] |=> !o_instr_done;
  endproperty
  a_decode: assert property (p_decode)
    else $error("instruction without bit 25 completed");

  property p_read_inv;
    go && op_read && !mc && ie != 2'h0 && e.inv |=>
      tag_r == 32'h0000_0400 && lo0_r == 32'h0 && lo1_r == 32'h0;
  endproperty
  a_read_inv: assert property (p_read_inv)
    else $error("invalid entry read returned wrong staging values");

  property p_read_g;
    go && op_read && !mc && !e.inv |=>
      lo0_r[LO_G_BIT] == lo1_r[LO_G_BIT] && lo0_r[LO_G_BIT] == $past(e.g);
  endproperty
  a_read_g: assert property (p_read_g)
    else $error("read global bits differ");

  property p_wr_g;
    go && op_wri && wr_norm && !mc |=>
      tlb[$past(idx_r)].g == $past(lo0_r[LO_G_BIT] & lo1_r[LO_G_BIT]);
  endproperty
  a_wr_g: assert property (p_wr_g)
    else $error("stored global bit is not the AND");

  property p_wr_inv;
    go && wr_inv |=> tlb[$past(idx_r)].inv && !o_exc.mchk;
  endproperty
  a_wr_inv: assert property (p_wr_inv)
    else $error("invalidating write failed");

  c_probe_hit: cover property (go && op_probe && (|ph));
  c_probe_miss: cover property (go && op_probe && !(|ph));
  c_wr_rand: cover property (go && op_wrr && !mc);
  c_mchk: cover property (o_exc.mchk);
endmodule : tlbm_top

// file: src/tlbm_pkg.sv
// Constants, register map and carrier types for the TLB maintenance block.
// Assumes a single core clock domain shared with the pipeline and APB.
package tlbm_pkg;
  localparam int VPN_W  = 19;
  localparam int PFN_W  = 20;
  localparam int MSK_W  = 16;
  localparam int ADDRESS_SPACE_ID_W = 8;

  localparam logic [7:0] OFS_TAG  = 8'h00;
  localparam logic [7:0] OFS_EVEN = 8'h04;
  localparam logic [7:0] OFS_ODD  = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_PTR  = 8'h10;
  localparam logic [7:0] OFS_RAND = 8'h14;
  localparam logic [7:0] OFS_CFG  = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;

  localparam int TAG_VPN_LSB = 13;
  localparam int TAG_R_LSB   = 11;
  localparam int TAG_INV_BIT = 10;
  localparam int LO_PFN_LSB  = 6;
  localparam int LO_C_LSB    = 3;
  localparam int LO_D_BIT    = 2;
  localparam int LO_V_BIT    = 1;
  localparam int LO_G_BIT    = 0;
  localparam int PM_LSB      = 13;
  localparam int PTR_MISS    = 31;
  localparam int CFG_MT_LSB  = 0;
  localparam int CFG_IE_LSB  = 4;
  localparam int CFG_REL_LSB = 8;

  localparam logic [31:0] TAG_WMASK = 32'hFFFF_FCFF;
  localparam logic [31:0] LO_WMASK  = 32'h03FF_FFFF;
  localparam logic [31:0] PM_WMASK  = 32'h1FFF_E000;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0737;
  localparam logic [31:0] CFG_RST   = 32'h0000_0201;
  localparam logic [31:0] REG_RST   = 32'h0000_0000;
  localparam logic [MSK_W-1:0] MIN_PAGE_MASK = 16'h0000;

  localparam logic [5:0] OPC_COP0 = 6'h10;
  localparam logic [5:0] FN_READ  = 6'h01;
  localparam logic [5:0] FN_WRI   = 6'h02;
  localparam logic [5:0] FN_WRR   = 6'h06;
  localparam logic [5:0] FN_PROBE = 6'h08;
  localparam logic [2:0] MT_BAT   = 3'h2;
  localparam logic [2:0] MT_FM    = 3'h3;
  localparam logic [2:0] REL_R3   = 3'h3;
  localparam logic [2:0] REL_R6   = 3'h6;

  typedef struct packed {
    logic              inv;
    logic [VPN_W-1:0]  vpn;
    logic [1:0]        r;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    logic [MSK_W-1:0]  msk;
    logic              g;
    logic [PFN_W-1:0]  pfn0;
    logic [2:0]        c0;
    logic              d0;
    logic              v0;
    logic [PFN_W-1:0]  pfn1;
    logic [2:0]        c1;
    logic              d1;
    logic              v1;
  } tlbm_entry_t;

  typedef struct packed {
    logic cpu;
    logic ri;
    logic mchk;
  } tlbm_exc_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tlbm_apb_req_t;
endpackage : tlbm_pkg

// file: testbench/tlbm_pipe_model.sv
// Pipeline model: issues one maintenance instruction word at a time.
// Assumes the unit answers exactly one cycle after it takes a word.
`timescale 1ns/1ps
module tlbm_pipe_model
  import tlbm_pkg::*;
(
  input  wire logic      i_clk_sys,
  output logic           o_instr_valid,
  output logic [31:0]    o_instr,
  output logic           o_cp0_en,
  input  wire logic      i_instr_done,
  input  wire tlbm_exc_t i_exc
);
  initial begin
    o_instr_valid = 1'b0;
    o_instr       = 32'h0000_0000;
    o_cp0_en      = 1'b1;
  end

  // The word is inverted after use, so a stale word is never seen as held.
  task automatic issue(input logic [31:0] word, input logic cp0,
                       output logic done, output tlbm_exc_t exc);
    @(posedge i_clk_sys);
    o_instr_valid <= 1'b1;
    o_instr       <= word;
    o_cp0_en      <= cp0;
    @(posedge i_clk_sys);
    o_instr_valid <= 1'b0;
    o_instr       <= ~word;
    @(negedge i_clk_sys);
    done = i_instr_done;
    exc  = i_exc;
  endtask : issue
endmodule : tlbm_pipe_model

// file: testbench/test_tlbm_top.sv
// Self-checking bench for the TLB maintenance unit.
// Assumes the register map of tlbm_pkg; APB waits follow pready.
`timescale 1ns/1ps
module test_tlbm_top;
  import tlbm_pkg::*;
  logic          clk_sys = 1'b0;
  logic          arst_n  = 1'b0;
  tlbm_apb_req_t bus     = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          valid;
  logic [31:0]   instr;
  logic          cp0_en;
  logic          done;
  tlbm_exc_t     exc;
  int            error_cnt       = 0;
  int            samples_checked = 0;
  int            cyc             = 0;
  logic [31:0]   rd;
  logic          err;
  logic          dn;
  tlbm_exc_t     ex;
  logic [5:0]    fns [4] = '{FN_PROBE, FN_READ, FN_WRI, FN_WRR};
  logic [31:0]   bad [3] = '{32'h4300_0008, 32'h4000_0008, 32'h4200_0003};

  tlbm_top tlbm_top_i (
    .i_clk_sys    (clk_sys),
    .i_arst_n     (arst_n),
    .i_apb        (bus),
    .o_prdata     (prdata),
    .o_pready     (pready),
    .o_pslverr    (pslverr),
    .i_instr_valid(valid),
    .i_instr      (instr),
    .i_cp0_en     (cp0_en),
    .o_instr_done (done),
    .o_exc        (exc)
  );

  tlbm_pipe_model tlbm_pipe_model_i (
    .i_clk_sys    (clk_sys),
    .o_instr_valid(valid),
    .o_instr      (instr),
    .o_cp0_en     (cp0_en),
    .i_instr_done (done),
    .i_exc        (exc)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // A hang is cut short well above the few hundred cycles the tests need.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] t=%0t timeout cycles=%h limit=%h", $time, cyc, 3000);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    bus.psel    <= 1'b1;
    bus.penable <= 1'b0;
    bus.pwrite  <= wr;
    bus.paddr   <= a;
    bus.pwdata  <= d;
    @(posedge clk_sys);
    bus.penable <= 1'b1;
    // Wait states are taken as the slave asks; only the bench timeout
    // ends a wait that never finishes.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    bus.psel    <= 1'b0;
    bus.penable <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic stage(input logic [31:0] t, input logic [31:0] e,
                       input logic [31:0] o, input logic [31:0] m,
                       input logic [31:0] p);
    xfer(1'b1, OFS_TAG, t);
    xfer(1'b1, OFS_EVEN, e);
    xfer(1'b1, OFS_ODD, o);
    xfer(1'b1, OFS_MASK, m);
    xfer(1'b1, OFS_PTR, p);
  endtask : stage

  task automatic op(input logic [5:0] fn, input logic cp0,
                    input logic [2:0] e);
    tlbm_pipe_model_i.issue({OPC_COP0, 1'b1, 19'h0, fn}, cp0, dn, ex);
    chk({31'h0, dn}, 32'h1);
    chk({29'h0, ex}, {29'h0, e});
  endtask : op

  task automatic probe_ptr(input logic [31:0] t);
    xfer(1'b1, OFS_TAG, t);
    op(FN_PROBE, 1'b1, 3'h0);
    xfer(1'b0, OFS_PTR, 32'h0);
  endtask : probe_ptr

  task automatic tend(input string s);
    $display("test %s ended, mismatches %0d", s, error_cnt);
  endtask : tend

  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk(OFS_CFG, CFG_RST);
    rdchk(OFS_PTR, REG_RST);
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    tend("reset");
    stage(32'h2468_A021, 32'h0002_AF1F, 32'h0003_7BDE, 32'h0, 32'h3);
    op(FN_WRI, 1'b1, 3'h0);
    stage(32'h0, 32'h0, 32'h0, 32'h0, 32'h3);
    op(FN_READ, 1'b1, 3'h0);
    rdchk(OFS_TAG, 32'h2468_A021);
    rdchk(OFS_EVEN, 32'h0002_AF1E);
    rdchk(OFS_ODD, 32'h0003_7BDE);
    tend("write_read");
    stage(32'h0020_2005, 32'h0000_0043, 32'h0000_0003, 32'h2000, 32'h5);
    op(FN_WRI, 1'b1, 3'h0);
    op(FN_READ, 1'b1, 3'h0);
    rdchk(OFS_TAG, 32'h0020_0005);
    rdchk(OFS_EVEN, 32'h0000_0003);
    rdchk(OFS_MASK, 32'h0000_2000);
    probe_ptr(32'h0020_0077);
    chk(rd, 32'h5);
    probe_ptr(32'h2468_A021);
    chk(rd, 32'h3);
    probe_ptr(32'h2468_A022);
    chk(rd & 32'h8000_0000, 32'h8000_0000);
    tend("probe");
    stage(32'h0020_0005, 32'h0000_0003, 32'h0000_0003, 32'h2000, 32'h7);
    op(FN_WRI, 1'b1, 3'h1);
    probe_ptr(32'h0020_0005);
    chk(rd, 32'h5);
    tend("multi");
    foreach (bad[k]) begin
      tlbm_pipe_model_i.issue(bad[k], 1'b1, dn, ex);
      chk({31'h0, dn}, 32'h0);
    end
    foreach (fns[k]) op(fns[k], 1'b0, 3'h4);
    xfer(1'b1, OFS_CFG, 32'h0000_0602);
    foreach (fns[k]) op(fns[k], 1'b1, 3'h2);
    xfer(1'b1, OFS_CFG, 32'h0000_0603);
    foreach (fns[k]) op(fns[k], 1'b1, 3'h2);
    tend("exceptions");
    xfer(1'b1, OFS_CFG, 32'h0000_0211);
    stage(32'h0000_0400, 32'h0, 32'h0, 32'h0, 32'h3);
    op(FN_WRI, 1'b1, 3'h0);
    stage(32'h2468_A021, 32'h5, 32'h5, 32'h2000, 32'h3);
    op(FN_READ, 1'b1, 3'h0);
    rdchk(OFS_TAG, 32'h0000_0400);
    rdchk(OFS_EVEN, 32'h0);
    rdchk(OFS_ODD, 32'h0);
    rdchk(OFS_MASK, {3'h0, MIN_PAGE_MASK, 13'h0});
    probe_ptr(32'h2468_A021);
    chk(rd & 32'h8000_0000, 32'h8000_0000);
    tend("invalidate");
    stage(32'h7000_0001, 32'h3, 32'h3, 32'h0, 32'h0);
    op(FN_WRR, 1'b1, 3'h0);
    probe_ptr(32'h7000_0001);
    chk(rd & 32'h8000_0000, 32'h0);
    xfer(1'b1, OFS_CFG, 32'h0000_0601);
    rdchk(OFS_RAND, 32'h0);
    tend("random");
    finish_test();
  end
endmodule : test_tlbm_top
